// ### shared/bpc_regs.vh
// Register offsets, field positions, reset values and timing counts of the
// batch pulse counter. Definitions only; included by bare name.
`ifndef BPC_REGS_VH
`define BPC_REGS_VH

// Clock and time base
`define BPC_CLK_HZ          25000000
`define BPC_MS_PER_S        1000
`define BPC_MS_CYCLES       (`BPC_CLK_HZ / `BPC_MS_PER_S)
`define BPC_RST_MIN_MS      2
`define BPC_PULSE_MAX_MS    32'h0000270f
`define BPC_PASS_MAX        32'h0000270f

// Register byte offsets
`define BPC_CTRL_OFF        12'h000
`define BPC_PULSE_OFF       12'h004
`define BPC_FIRST_SETPOINT_OFF        12'h008
`define BPC_SECOND_SETPOINT_OFF        12'h00c
`define BPC_COEF_OFF        12'h010
`define BPC_PASS_OFF        12'h014
`define BPC_UNLOCK_OFF      12'h018
`define BPC_COUNT_OFF       12'h01c
`define BPC_BATCH_OFF       12'h020
`define BPC_TOTAL_OFF       12'h024
`define BPC_ACTUAL_OFF      12'h028
`define BPC_STATUS_OFF      12'h02c

// Control register fields
`define BPC_CTRL_MODE_LSB   0
`define BPC_CTRL_MODE_MSB   2
`define BPC_CTRL_OFFSET_BIT 8
`define BPC_CTRL_AUTO_BIT   9
`define BPC_CTRL_DOWN_BIT   10
`define BPC_CTRL_SHOW_LSB   11
`define BPC_CTRL_SHOW_MSB   12

// Input modes
`define BPC_MODE_INC        3'h0
`define BPC_MODE_DEC        3'h1
`define BPC_MODE_INCDEC     3'h2
`define BPC_MODE_INCINC     3'h3
`define BPC_MODE_UPDOWN     3'h4
`define BPC_MODE_QX1        3'h5
`define BPC_MODE_QX2        3'h6
`define BPC_MODE_QX4        3'h7

// Displayed setpoint selection
`define BPC_SHOW_FIRST_SETPOINT       2'h1

// Reset values; coefficient is unsigned 16.16 fixed point
`define BPC_CTRL_RST        32'h00000000
`define BPC_PULSE_RST       32'h00000000
`define BPC_SET_RST         32'h00000000
`define BPC_COEF_RST        32'h00010000
`define BPC_PASS_RST        32'h00000000
`define BPC_COEF_FRAC       16

`endif

// ### design/bpc_filter.v
// Pin synchroniser and minimum pulse time filter for one input.
// Assumes an asynchronous pin and a length in pclk cycles from the same domain.
`timescale 1ns/1ps
`default_nettype none

module bpc_filter (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        pin,
    input  wire [31:0] min_cycles,
    output wire        level
);
    reg        s1_reg;
    reg        s2_reg;
    reg        s3_reg;
    reg        agreed_reg;
    reg        level_reg;
    reg [31:0] cnt_reg;
    wire       agreed_next;

    // Three stages; a change counts once stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg     <= 1'b0;
            s2_reg     <= 1'b0;
            s3_reg     <= 1'b0;
            agreed_reg <= 1'b0;
        end else begin
            s1_reg     <= pin;
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            agreed_reg <= agreed_next;
        end
    end

    assign agreed_next = (s2_reg == s3_reg) ? s3_reg : agreed_reg;

    // New level must stand min_cycles before it is taken
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_reg <= 1'b0;
            cnt_reg   <= 32'h00000000;
        end else if (agreed_reg == level_reg) begin
            cnt_reg <= 32'h00000000;
        end else if (cnt_reg >= min_cycles) begin
            level_reg <= agreed_reg;
            cnt_reg   <= 32'h00000000;
        end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
        end
    end

    assign level = level_reg;
endmodule

`default_nettype wire

// ### design/bpc_counter.v
// Batch and totalising pulse counter with APB register access.
// Assumes one 25 MHz pclk, asynchronous count, reset and pause pins.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_regs.vh"

//Function
// - Password gates parameter writes; zero disables it
// - Single up mode: first input rises, increment
// - Single down mode: first input rises, decrement
// - Split mode: first increments, second decrements
// - Dual mode: both inputs increment the count
// - Direction mode: second input selects up/down
// - Quadrature decoding at x1, x2, x4
// - Reject input pulses shorter than set time
// - Zero pulse time: count inputs unfiltered
// - Reset and pause keep 2 ms minimum
// - Reset showing first setpoint clears batch only
// - Reset showing second setpoint clears normal count
// - Offset: threshold one is setpoint two plus one
// - Actual value is count times coefficient
// - Manual reset not showing first setpoint adds count to total
// - First setpoint controls output one
// - Second setpoint controls output two
// - Auto batch reset when batch counts up to setpoint one
// - Downward direction reloads second setpoint on reset
module bpc_counter #(
    parameter MS_CYCLES = `BPC_MS_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        first_count_input,
    input  wire        second_count_input,
    input  wire        manual_reset_in,
    input  wire        pause_in,
    output wire        output_one,
    output wire        output_two
);
    reg         [31:0] ctrl_reg;
    reg         [31:0] pulse_reg;
    reg  signed [31:0] first_setpoint_reg;
    reg  signed [31:0] second_setpoint_reg;
    reg         [31:0] coef_reg;
    reg         [31:0] pass_reg;
    reg                unlock_reg;
    reg  signed [31:0] count_reg;
    reg  signed [31:0] batch_reg;
    reg  signed [31:0] total_reg;
    reg  signed [31:0] actual_reg;
    reg         [31:0] prdata_reg;
    reg                pslverr_reg;
    reg                out1_reg;
    reg                out2_reg;
    reg                a_prev_reg;
    reg                b_prev_reg;
    reg                rst_prev_reg;
    reg         [31:0] cnt_cyc_reg;
    reg         [31:0] ctl_cyc_reg;

    wire               a_lvl;
    wire               b_lvl;
    wire               rst_lvl;
    wire               pause_lvl;
    wire         [2:0] mode;
    wire               offset_en;
    wire               auto_en;
    wire               dir_down;
    wire         [1:0] show_sel;
    wire               setup;
    wire               wr_en;
    wire               param_ok;
    wire               a_rise;
    wire               b_rise;
    wire               a_chg;
    wire               b_chg;
    wire               rst_rise;
    wire signed [31:0] thr1;
    wire signed [31:0] cmp1_val;
    wire signed [63:0] product;

    reg  signed [31:0] delta;
    reg  signed [31:0] count_next;
    reg  signed [31:0] batch_next;
    reg  signed [31:0] total_next;
    reg         [31:0] rdata_next;
    reg                err_next;

    // Known offset test, shared by read and write decode
    function mapped;
        input [11:0] addr;
        begin
            mapped = (addr[1:0] == 2'h0) && (addr <= `BPC_STATUS_OFF);
        end
    endfunction

    assign mode      = ctrl_reg[`BPC_CTRL_MODE_MSB:`BPC_CTRL_MODE_LSB];
    assign offset_en = ctrl_reg[`BPC_CTRL_OFFSET_BIT];
    assign auto_en   = ctrl_reg[`BPC_CTRL_AUTO_BIT];
    assign dir_down  = ctrl_reg[`BPC_CTRL_DOWN_BIT];
    assign show_sel  = ctrl_reg[`BPC_CTRL_SHOW_MSB:`BPC_CTRL_SHOW_LSB];

    // Filter lengths registered to keep the multiplier off the filter path
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_cyc_reg <= 32'h00000000;
            ctl_cyc_reg <= 32'h00000000;
        end else begin
            cnt_cyc_reg <= pulse_reg * MS_CYCLES;
            if (pulse_reg < `BPC_RST_MIN_MS)
                ctl_cyc_reg <= `BPC_RST_MIN_MS * MS_CYCLES;
            else
                ctl_cyc_reg <= pulse_reg * MS_CYCLES;
        end
    end

    bpc_filter u_filt_a (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (first_count_input),
        .min_cycles (cnt_cyc_reg),
        .level      (a_lvl)
    );

    bpc_filter u_filt_b (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (second_count_input),
        .min_cycles (cnt_cyc_reg),
        .level      (b_lvl)
    );

    bpc_filter u_filt_rst (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (manual_reset_in),
        .min_cycles (ctl_cyc_reg),
        .level      (rst_lvl)
    );

    bpc_filter u_filt_pause (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (pause_in),
        .min_cycles (ctl_cyc_reg),
        .level      (pause_lvl)
    );

    // Edge history keeps running in pause so no stale edge fires on release
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_prev_reg   <= 1'b0;
            b_prev_reg   <= 1'b0;
            rst_prev_reg <= 1'b0;
        end else begin
            a_prev_reg   <= a_lvl;
            b_prev_reg   <= b_lvl;
            rst_prev_reg <= rst_lvl;
        end
    end

    assign a_rise   = a_lvl & ~a_prev_reg;
    assign b_rise   = b_lvl & ~b_prev_reg;
    assign a_chg    = a_lvl ^ a_prev_reg;
    assign b_chg    = b_lvl ^ b_prev_reg;
    assign rst_rise = rst_lvl & ~rst_prev_reg;

    // Step per cycle from the selected input mode
    always @* begin
        delta = 32'sh00000000;
        case (mode)
            `BPC_MODE_INC: begin
                if (a_rise)
                    delta = 32'sh00000001;
            end
            `BPC_MODE_DEC: begin
                if (a_rise)
                    delta = -32'sh00000001;
            end
            `BPC_MODE_INCDEC: begin
                if (a_rise && !b_rise)
                    delta = 32'sh00000001;
                else if (b_rise && !a_rise)
                    delta = -32'sh00000001;
            end
            `BPC_MODE_INCINC: begin
                if (a_rise && b_rise)
                    delta = 32'sh00000002;
                else if (a_rise || b_rise)
                    delta = 32'sh00000001;
            end
            `BPC_MODE_UPDOWN: begin
                if (a_rise)
                    delta = b_lvl ? -32'sh00000001 : 32'sh00000001;
            end
            `BPC_MODE_QX1: begin
                if (a_rise)
                    delta = b_lvl ? -32'sh00000001 : 32'sh00000001;
            end
            `BPC_MODE_QX2: begin
                if (a_chg)
                    delta = (a_lvl != b_lvl) ? 32'sh00000001 : -32'sh00000001;
            end
            `BPC_MODE_QX4: begin
                // A double change is an illegal jump and is dropped
                if (a_chg ^ b_chg)
                    delta = (a_lvl ^ b_prev_reg) ? 32'sh00000001 : -32'sh00000001;
            end
            default: delta = 32'sh00000000;
        endcase
    end

    // Count, batch and total updates
    always @* begin
        count_next = count_reg;
        batch_next = batch_reg;
        total_next = total_reg;
        if (!pause_lvl) begin
            if (rst_rise) begin
                if (show_sel == `BPC_SHOW_FIRST_SETPOINT) begin
                    batch_next = 32'sh00000000;
                end else begin
                    total_next = total_reg + count_reg;
                    count_next = dir_down ? second_setpoint_reg
                                          : 32'sh00000000;
                end
            end else begin
                count_next = count_reg + delta;
                batch_next = batch_reg + delta;
                if (auto_en && (delta > 0) && (batch_next == first_setpoint_reg))
                    batch_next = 32'sh00000000;
            end
        end
    end

    assign thr1     = offset_en ? (second_setpoint_reg + first_setpoint_reg)
                                : first_setpoint_reg;
    assign cmp1_val = offset_en ? count_reg : batch_reg;
    assign product  = count_reg * $signed({1'b0, coef_reg[30:0]});

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg  <= 32'sh00000000;
            batch_reg  <= 32'sh00000000;
            total_reg  <= 32'sh00000000;
            actual_reg <= 32'sh00000000;
            out1_reg   <= 1'b0;
            out2_reg   <= 1'b0;
        end else begin
            count_reg  <= count_next;
            batch_reg  <= batch_next;
            total_reg  <= total_next;
            actual_reg <= product[`BPC_COEF_FRAC+31:`BPC_COEF_FRAC];
            if (dir_down) begin
                out1_reg <= (cmp1_val <= thr1);
                out2_reg <= (count_reg <= 32'sh00000000);
            end else begin
                out1_reg <= (cmp1_val >= thr1);
                out2_reg <= (count_reg >= second_setpoint_reg);
            end
        end
    end

    assign output_one = out1_reg;
    assign output_two = out2_reg;

    // APB: decode in setup, answer with zero wait states in access
    assign setup    = psel & ~penable;
    assign wr_en    = psel & penable & pwrite & mapped(paddr);
    assign param_ok = (pass_reg == 32'h00000000) | unlock_reg;

    always @* begin
        rdata_next = 32'h00000000;
        err_next   = ~mapped(paddr);
        case (paddr)
            `BPC_CTRL_OFF:   rdata_next = ctrl_reg;
            `BPC_PULSE_OFF:  rdata_next = pulse_reg;
            `BPC_FIRST_SETPOINT_OFF:   rdata_next = first_setpoint_reg;
            `BPC_SECOND_SETPOINT_OFF:   rdata_next = second_setpoint_reg;
            `BPC_COEF_OFF:   rdata_next = coef_reg;
            `BPC_PASS_OFF:   rdata_next = 32'h00000000;
            `BPC_UNLOCK_OFF: rdata_next = {31'h00000000, param_ok};
            `BPC_COUNT_OFF:  rdata_next = count_reg;
            `BPC_BATCH_OFF:  rdata_next = batch_reg;
            `BPC_TOTAL_OFF:  rdata_next = total_reg;
            `BPC_ACTUAL_OFF: rdata_next = actual_reg;
            `BPC_STATUS_OFF: rdata_next = {26'h0000000, param_ok, pause_lvl, rst_lvl,
                                           b_lvl, out2_reg, out1_reg};
            default:         rdata_next = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= pwrite ? 32'h00000000 : rdata_next;
            pslverr_reg <= err_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & pslverr_reg;

    // Parameter writes; the password itself stays write-only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg            <= `BPC_CTRL_RST;
            pulse_reg           <= `BPC_PULSE_RST;
            first_setpoint_reg  <= `BPC_SET_RST;
            second_setpoint_reg <= `BPC_SET_RST;
            coef_reg            <= `BPC_COEF_RST;
            pass_reg            <= `BPC_PASS_RST;
            unlock_reg          <= 1'b0;
        end else if (wr_en) begin
            if (paddr == `BPC_UNLOCK_OFF)
                unlock_reg <= (pwdata == pass_reg);
            else if (param_ok) begin
                case (paddr)
                    `BPC_CTRL_OFF:  ctrl_reg <= pwdata;
                    `BPC_PULSE_OFF: begin
                        if (pwdata <= `BPC_PULSE_MAX_MS)
                            pulse_reg <= pwdata;
                    end
                    `BPC_FIRST_SETPOINT_OFF:  first_setpoint_reg  <= pwdata;
                    `BPC_SECOND_SETPOINT_OFF:  second_setpoint_reg <= pwdata;
                    `BPC_COEF_OFF:  coef_reg <= pwdata;
                    `BPC_PASS_OFF: begin
                        if (pwdata <= `BPC_PASS_MAX)
                            pass_reg <= pwdata;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// ### bench/bpc_counter_asserts.sv
// Register bus checks for the pulse counter, bound to its top.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_regs.vh"
module bpc_counter_asserts #(
    parameter MS_CYCLES = 4
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        first_count_input,
    input wire logic        second_count_input,
    input wire logic        manual_reset_in,
    input wire logic        pause_in,
    input wire logic        output_one,
    input wire logic        output_two
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable;
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err_phase; pslverr |-> acc; endproperty
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
    property p_err_unal; acc && (paddr[1:0] != 2'h0) |-> pslverr; endproperty
    a_err_unal: assert property (p_err_unal) else $error("unaligned not refused");
    property p_err_high; acc && (paddr > `BPC_STATUS_OFF) |-> pslverr; endproperty
    a_err_high: assert property (p_err_high) else $error("unmapped not refused");
    property p_ok_map;
        acc && (paddr[1:0] == 2'h0) && (paddr <= `BPC_STATUS_OFF) |-> !pslverr;
    endproperty
    a_ok_map: assert property (p_ok_map) else $error("mapped access refused");
    property p_err_zero; acc && !pwrite && pslverr |-> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
    property p_pass_zero;
        acc && !pwrite && (paddr == `BPC_PASS_OFF) |-> prdata == 32'h0;
    endproperty
    a_pass_zero: assert property (p_pass_zero) else $error("password readable");
    // Read data must survive into the idle cycle after the access
    property p_rd_hold; acc ##1 !psel |-> $stable(prdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
    c_err: cover property (acc && pslverr);
    c_out1: cover property ($rose(output_one));
    c_out2: cover property ($rose(output_two));
endmodule
bind bpc_counter bpc_counter_asserts #(.MS_CYCLES(MS_CYCLES)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_count_input(first_count_input), .second_count_input(second_count_input),
    .manual_reset_in(manual_reset_in), .pause_in(pause_in),
    .output_one(output_one), .output_two(output_two));
`default_nettype wire

// ### bench/bpc_pulse_source.sv
// Sensor and encoder stand-in driving both count pins.
// Assumes callers run on pclk; pins are push-pull levels.
`timescale 1ns/1ps
`default_nettype none
module bpc_pulse_source (
    input  wire logic pclk,
    output var  logic chan_a,
    output var  logic chan_b
);
    initial begin
        chan_a = 1'b0;
        chan_b = 1'b0;
    end
    task automatic level(input logic ch, input logic v);
        @(posedge pclk);
        if (ch) chan_b <= v;
        else chan_a <= v;
    endtask
    task automatic pulse(input logic ch, input int len);
        level(ch, 1'b1);
        repeat (len) @(posedge pclk);
        level(ch, 1'b0);
        repeat (len) @(posedge pclk);
    endtask
    // One full encoder cycle; forward has the first channel leading
    task automatic quad(input logic fwd, input int len);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            {chan_a, chan_b} <= fwd ? {i < 2, i == 1 || i == 2} : {i == 1 || i == 2, i < 2};
            repeat (len) @(posedge pclk);
        end
    endtask
endmodule
`default_nettype wire

// ### bench/test_bpc_counter.sv
// Self-checking bench for the batch pulse counter through its register bus.
// Assumes the pulse source on both count pins; 25 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_regs.vh"
module test_bpc_counter;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        manual_reset_in = 1'b0;
    logic        pause_in = 1'b0;
    wire  logic [31:0] prdata;
    wire  logic  pready, pslverr, output_one, output_two, chan_a, chan_b;
    int          failures = 0;
    int          comparisons = 0;
    int          tot;
    int          dexp [5] = '{2, -2, 1, 3, 2};
    logic [31:0] q;
    logic        e;
    always #20 pclk = ~pclk;
    // Short millisecond keeps filter waits small
    bpc_counter #(.MS_CYCLES(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .first_count_input(chan_a), .second_count_input(chan_b),
        .manual_reset_in(manual_reset_in), .pause_in(pause_in),
        .output_one(output_one), .output_two(output_two));
    bpc_pulse_source src_u (.pclk(pclk), .chan_a(chan_a), .chan_b(chan_b));
    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            if (n > 50) begin
                failures++;
                report_and_stop();
            end
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, q);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic mrst;
        @(posedge pclk) manual_reset_in <= 1'b1;
        idle(30);
        manual_reset_in <= 1'b0;
        idle(30);
    endtask
    task automatic pulses(input int n);
        repeat (n) src_u.pulse(1'b0, 6);
        idle(10);
    endtask
    task automatic outs(input logic x1, input logic x2);
        chk("out1", {31'h0, x1}, {31'h0, output_one});
        chk("out2", {31'h0, x2}, {31'h0, output_two});
    endtask
    initial begin
        idle(10);
        presetn <= 1'b1;
        rdc("ctrl", `BPC_CTRL_OFF, `BPC_CTRL_RST);
        rdc("coef", `BPC_COEF_OFF, `BPC_COEF_RST);
        rdc("first_setpoint", `BPC_FIRST_SETPOINT_OFF, `BPC_SET_RST);
        apb(1'b0, 12'h030, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        rdc("unaligned data", 12'h005, 32'h0);
        chk("unaligned err", 32'h1, {31'h0, e});
        wr(`BPC_PASS_OFF, 32'h00001234);
        rdc("pass hidden", `BPC_PASS_OFF, 32'h0);
        wr(`BPC_SECOND_SETPOINT_OFF, 32'h5);
        rdc("locked second_setpoint", `BPC_SECOND_SETPOINT_OFF, 32'h0);
        wr(`BPC_UNLOCK_OFF, 32'h00001234);
        rdc("unlock", `BPC_UNLOCK_OFF, 32'h1);
        wr(`BPC_PASS_OFF, 32'h0);
        wr(`BPC_UNLOCK_OFF, 32'h1);
        // Above the top code, so the zero password must stay
        wr(`BPC_PASS_OFF, 32'h00002710);
        wr(`BPC_SECOND_SETPOINT_OFF, 32'h7);
        rdc("open second_setpoint", `BPC_SECOND_SETPOINT_OFF, 32'h7);
        // Open access, batch at setpoint one, count below setpoint two
        rdc("status", `BPC_STATUS_OFF, 32'h00000021);
        tot = 0;
        for (int m = 0; m < 5; m++) begin
            wr(`BPC_CTRL_OFF, 32'(m));
            mrst();
            rdc("total", `BPC_TOTAL_OFF, 32'(tot));
            src_u.pulse(1'b0, 6);
            src_u.pulse(1'b0, 6);
            src_u.pulse(1'b1, 6);
            idle(10);
            rdc("mode count", `BPC_COUNT_OFF, 32'(dexp[m]));
            tot += dexp[m];
        end
        src_u.level(1'b1, 1'b1);
        idle(10);
        src_u.pulse(1'b0, 6);
        src_u.level(1'b1, 1'b0);
        idle(10);
        rdc("dir count", `BPC_COUNT_OFF, 32'h1);
        for (int m = 5; m < 8; m++) begin
            wr(`BPC_CTRL_OFF, 32'(m));
            mrst();
            src_u.quad(1'b1, 8);
            idle(10);
            apb(1'b0, `BPC_COUNT_OFF, 32'h0);
            chk("quad fwd", 32'(1 << (m - 5)), q[31] ? -q : q);
            src_u.quad(1'b0, 8);
            idle(10);
            rdc("quad back", `BPC_COUNT_OFF, 32'h0);
        end
        wr(`BPC_CTRL_OFF, 32'h0);
        mrst();
        wr(`BPC_CTRL_OFF, 32'h00000800);
        mrst();
        wr(`BPC_FIRST_SETPOINT_OFF, 32'h2);
        wr(`BPC_SECOND_SETPOINT_OFF, 32'h3);
        pulses(2);
        outs(1'b1, 1'b0);
        pulses(1);
        outs(1'b1, 1'b1);
        mrst();
        rdc("batch", `BPC_BATCH_OFF, 32'h0);
        rdc("kept count", `BPC_COUNT_OFF, 32'h3);
        outs(1'b0, 1'b1);
        wr(`BPC_COEF_OFF, 32'h00008000);
        pulses(1);
        rdc("actual", `BPC_ACTUAL_OFF, 32'h2);
        wr(`BPC_CTRL_OFF, 32'h0);
        mrst();
        rdc("count", `BPC_COUNT_OFF, 32'h0);
        wr(`BPC_CTRL_OFF, 32'h00000800);
        mrst();
        wr(`BPC_CTRL_OFF, 32'h00000200);
        pulses(2);
        rdc("auto batch", `BPC_BATCH_OFF, 32'h0);
        wr(`BPC_FIRST_SETPOINT_OFF, 32'hffffffff);
        wr(`BPC_CTRL_OFF, 32'h00000100);
        idle(5);
        outs(1'b1, 1'b0);
        wr(`BPC_SECOND_SETPOINT_OFF, 32'h4);
        idle(5);
        outs(1'b0, 1'b0);
        wr(`BPC_CTRL_OFF, 32'h00000400);
        mrst();
        rdc("reload", `BPC_COUNT_OFF, 32'h4);
        wr(`BPC_CTRL_OFF, 32'h0);
        pause_in <= 1'b1;
        idle(30);
        pulses(2);
        mrst();
        rdc("paused count", `BPC_COUNT_OFF, 32'h4);
        pause_in <= 1'b0;
        idle(30);
        // Short reset pulse must be swallowed even with zero pulse time
        manual_reset_in <= 1'b1;
        idle(5);
        manual_reset_in <= 1'b0;
        idle(20);
        rdc("short reset", `BPC_COUNT_OFF, 32'h4);
        wr(`BPC_PULSE_OFF, 32'h3);
        mrst();
        src_u.pulse(1'b0, 5);
        src_u.pulse(1'b0, 40);
        idle(20);
        rdc("filtered", `BPC_COUNT_OFF, 32'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
